// ===== core/fsr_top.sv
`timescale 1ns/1ns
`include "fsr_regs.svh"
module fsr_top
  import fsr_pkg::*;
(
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic RST_N,
  // Avalon-MM slave
  input wire logic [9:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  // Fault sources, asynchronous levels
  input wire logic CRC_ERROR_IN,
  input wire logic COEF_WRITE_ERROR_IN,
  input wire logic BOOT_LOAD_ERROR_IN,
  input wire logic CLOCK_FAULT_IN,
  input wire logic SUPPLY_OV_IN,
  input wire logic SUPPLY_UV_IN,
  input wire logic RIGHT_CURRENT_FAULT_IN,
  input wire logic LEFT_CURRENT_FAULT_IN,
  input wire logic THERMAL_SHUTDOWN_IN,
  input wire logic LEFT_CURRENT_WARN_IN,
  input wire logic RIGHT_CURRENT_WARN_IN,
  input wire logic [3:0] THERMAL_WARN_IN,
  // Outputs
  output logic OUTPUT_HIZ,
  output logic FAULT_PIN_N,
  output logic IRQ
);

  // ==========================================
  // Input synchronisers, three stages
  localparam int NIN = 15;
  logic [NIN-1:0] raw;
  logic [NIN-1:0] s1_r;
  logic [NIN-1:0] s2_r;
  logic [NIN-1:0] s3_r;
  logic [NIN-1:0] live_r;

  assign raw = {THERMAL_WARN_IN, RIGHT_CURRENT_WARN_IN, LEFT_CURRENT_WARN_IN,
                THERMAL_SHUTDOWN_IN, LEFT_CURRENT_FAULT_IN, RIGHT_CURRENT_FAULT_IN,
                SUPPLY_UV_IN, SUPPLY_OV_IN, CLOCK_FAULT_IN, BOOT_LOAD_ERROR_IN,
                COEF_WRITE_ERROR_IN, CRC_ERROR_IN};

  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_N)
      s1_r <= '0;
    else
      s1_r <= raw;
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_N)
      s2_r <= '0;
    else
      s2_r <= s1_r;
  end

  // Third stage exists only to vote against the second
  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_N)
      s3_r <= '0;
    else
      s3_r <= s2_r;
  end

  // Change accepted only once stages two and three agree
  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_N)
      live_r <= '0;
    else
    begin
      for (int i = 0; i < NIN; i++)
      begin
        if (s2_r[i] == s3_r[i])
          live_r[i] <= s3_r[i];
      end
    end
  end

  logic crc_l;
  logic coef_l;
  logic boot_l;
  logic clk_l;
  logic ov_l;
  logic uv_l;
  logic rcur_l;
  logic lcur_l;
  logic otsd_l;
  logic lwarn_l;
  logic rwarn_l;
  logic [3:0] twarn_l;
  assign {twarn_l, rwarn_l, lwarn_l, otsd_l, lcur_l, rcur_l,
          uv_l, ov_l, clk_l, boot_l, coef_l, crc_l} = live_r;

  // ==========================================
  // Bus decode
  fsr_bus_e bus_state_r;
  logic acc_wr;
  logic acc_rd;
  logic [7:0] idx;
  logic lane0;
  assign idx = AVS_ADDRESS[9:2];
  assign lane0 = AVS_BYTEENABLE[0];
  // Write lands at the edge where the master sees waitrequest low
  assign acc_wr = (bus_state_r == FSR_DONE) && AVS_WRITE;
  // Read byte launched one cycle ahead so it stands at that edge
  assign acc_rd = (bus_state_r == FSR_WAIT) && AVS_READ;

  logic clear_pulse;
  logic wr_lane0;
  logic wr_irq_clear;
  logic wr_irq_enable;
  logic [7:0] irq_clear_w;
  // Only lane 0 carries the byte registers
  assign wr_lane0 = acc_wr && lane0;
  // Status register writes fall through: nothing decodes them
  assign clear_pulse = wr_lane0 && (idx == `FSR_IDX_CLEAR)
                       && AVS_WRITEDATA[`FSR_CLEAR_BIT];
  assign wr_irq_clear = wr_lane0 && (idx == `FSR_IDX_IRQ_CLEAR);
  assign wr_irq_enable = wr_lane0 && (idx == `FSR_IDX_IRQ_ENABLE);
  assign irq_clear_w = wr_irq_clear ? AVS_WRITEDATA[7:0] : 8'h00;

  // ==========================================
  // Latched faults; set wins over clear
  fsr_byte_t fault_one_r;
  fsr_byte_t fault_two_r;
  fsr_byte_t warn_r;
  fsr_byte_t f1_set;
  fsr_byte_t f2_set;
  fsr_byte_t w_set;
  fsr_byte_t f1_sticky_r;
  logic boot_r;

  always_comb
  begin
    f1_set = 8'h00;
    f1_set[`FSR_F1_CRC] = crc_l;
    f1_set[`FSR_F1_COEF] = coef_l;
    f1_set[`FSR_F1_CLK] = clk_l;
    f1_set[`FSR_F1_OV] = ov_l;
    f1_set[`FSR_F1_UV] = uv_l;
  end

  always_comb
  begin
    f2_set = 8'h00;
    f2_set[`FSR_F2_RIGHT] = rcur_l;
    f2_set[`FSR_F2_LEFT] = lcur_l;
    f2_set[`FSR_F2_OTSD] = otsd_l;
  end

  always_comb
  begin
    w_set = {2'b00, lwarn_l, rwarn_l, twarn_l};
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_N)
      f1_sticky_r <= `FSR_RST_BYTE;
    else
    begin
      // Flags hold after recovery until cleared
      f1_sticky_r <= ((clear_pulse ? 8'h00 : f1_sticky_r) | f1_set) & `FSR_F1_MASK;
    end
  end

  // Boot result is a status level, not a sticky flag
  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_N)
      boot_r <= 1'b0;
    else
      boot_r <= boot_l;
  end

  always_comb
  begin
    fault_one_r = f1_sticky_r;
    fault_one_r[`FSR_F1_BOOT] = boot_r;
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_N)
      fault_two_r <= `FSR_RST_BYTE;
    else
      fault_two_r <= ((clear_pulse ? 8'h00 : fault_two_r) | f2_set) & `FSR_F2_MASK;
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_N)
      warn_r <= `FSR_RST_BYTE;
    else
      warn_r <= ((clear_pulse ? 8'h00 : warn_r) | w_set) & `FSR_WARN_MASK;
  end

  // ==========================================
  // Output stage follows live conditions so it recovers on its own
  logic stop_w;
  // Serious faults only; current faults keep the outputs driving
  assign stop_w = clk_l | ov_l | uv_l | otsd_l;

  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_N)
      OUTPUT_HIZ <= 1'b0;
    else
      OUTPUT_HIZ <= stop_w;
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_N)
      FAULT_PIN_N <= 1'b1;
    else
      FAULT_PIN_N <= ~stop_w;
  end

  // ==========================================
  // Interrupts: bit0 fault one, bit1 fault two, bit2 warning
  fsr_byte_t irq_status_r;
  fsr_byte_t irq_enable_r;
  fsr_byte_t irq_ev;
  logic [7:0] f1_prev_r;
  logic [7:0] f2_prev_r;
  logic [7:0] w_prev_r;
  logic f1_rise;
  logic f2_rise;
  logic w_rise;

  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_N)
      f1_prev_r <= 8'h00;
    else
      f1_prev_r <= fault_one_r;
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_N)
      f2_prev_r <= 8'h00;
    else
      f2_prev_r <= fault_two_r;
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_N)
      w_prev_r <= 8'h00;
    else
      w_prev_r <= warn_r;
  end

  // Rising bits only, so a held fault interrupts once
  assign f1_rise = |(fault_one_r & ~f1_prev_r);
  assign f2_rise = |(fault_two_r & ~f2_prev_r);
  assign w_rise = |(warn_r & ~w_prev_r);
  assign irq_ev = {5'b00000, w_rise, f2_rise, f1_rise};

  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_N)
      irq_status_r <= 8'h00;
    else
      irq_status_r <= ((irq_status_r & ~irq_clear_w) | irq_ev) & `FSR_IRQ_MASK;
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_N)
      irq_enable_r <= 8'h00;
    else if (wr_irq_enable)
      irq_enable_r <= AVS_WRITEDATA[7:0] & `FSR_IRQ_MASK;
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_N)
      IRQ <= 1'b0;
    else
      IRQ <= |(irq_status_r & irq_enable_r);
  end

  // ==========================================
  // Bus handshake and read mux
  fsr_byte_t rd_byte;
  always_comb
  begin
    unique case (idx)
      `FSR_IDX_FAULT_ONE: rd_byte = fault_one_r;
      `FSR_IDX_FAULT_TWO: rd_byte = fault_two_r;
      `FSR_IDX_WARNING: rd_byte = warn_r;
      `FSR_IDX_IRQ_STATUS: rd_byte = irq_status_r;
      `FSR_IDX_IRQ_ENABLE: rd_byte = irq_enable_r;
      `FSR_IDX_CLEAR: rd_byte = 8'h00;
      `FSR_IDX_IRQ_CLEAR: rd_byte = 8'h00;
      default: rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_N)
      bus_state_r <= FSR_IDLE;
    else
    begin
      unique case (bus_state_r)
        FSR_IDLE:
        begin
          if (AVS_READ || AVS_WRITE)
            bus_state_r <= FSR_WAIT;
        end
        FSR_WAIT:
          bus_state_r <= FSR_DONE;
        FSR_DONE:
          bus_state_r <= FSR_IDLE;
        default:
          bus_state_r <= FSR_IDLE;
      endcase
    end
  end

  // Low only through the DONE cycle
  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_N)
      AVS_WAITREQUEST <= 1'b1;
    else
      AVS_WAITREQUEST <= (bus_state_r != FSR_WAIT);
  end

  // Data stands until the next answer
  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_N)
      AVS_READDATA <= 32'h00000000;
    else if (bus_state_r == FSR_WAIT)
      AVS_READDATA <= acc_rd ? {24'h000000, rd_byte} : 32'h00000000;
  end

endmodule

// ===== inc/fsr_regs.svh
`ifndef FSR_REGS_SVH
`define FSR_REGS_SVH

// ==========================================
// Register word offsets (byte address = 4 x index)
`define FSR_IDX_FAULT_ONE 8'h71
`define FSR_IDX_FAULT_TWO 8'h72
`define FSR_IDX_WARNING 8'h73
`define FSR_IDX_CLEAR 8'h78
`define FSR_IDX_IRQ_STATUS 8'h79
`define FSR_IDX_IRQ_ENABLE 8'h7A
`define FSR_IDX_IRQ_CLEAR 8'h7B

// ==========================================
// Field positions
`define FSR_F1_CRC 7
`define FSR_F1_COEF 6
`define FSR_F1_BOOT 5
`define FSR_F1_CLK 2
`define FSR_F1_OV 1
`define FSR_F1_UV 0
`define FSR_F2_RIGHT 2
`define FSR_F2_LEFT 1
`define FSR_F2_OTSD 0
`define FSR_CLEAR_BIT 7

// ==========================================
// Reset values and masks
`define FSR_RST_BYTE 8'h00
`define FSR_F1_MASK 8'hE7
`define FSR_F2_MASK 8'h07
`define FSR_WARN_MASK 8'h3F
`define FSR_IRQ_MASK 8'h07
`endif

// ===== inc/fsr_pkg.sv
package fsr_pkg;
  typedef logic [7:0] fsr_byte_t;
  typedef enum logic [2:0]
  {
    FSR_IDLE = 3'b001,
    FSR_WAIT = 3'b010,
    FSR_DONE = 3'b100
  } fsr_bus_e;
endpackage

// ===== testbench/fsr_top_properties.sv
`timescale 1ns/1ns
module fsr_top_chk
(
  // Watched ports
  input wire logic CORE_CLK,
  input wire logic RST_N,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_READDATA,
  input wire logic AVS_WAITREQUEST,
  input wire logic CLOCK_FAULT_IN,
  input wire logic SUPPLY_OV_IN,
  input wire logic SUPPLY_UV_IN,
  input wire logic THERMAL_SHUTDOWN_IN,
  input wire logic OUTPUT_HIZ,
  input wire logic FAULT_PIN_N
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);
  // ==========================================
  // Bus handshake
  sequence s_answer;
    AVS_WAITREQUEST [*2] ##1 !AVS_WAITREQUEST;
  endsequence
  a_answer_two: assert property ($rose(AVS_READ || AVS_WRITE) |-> s_answer)
    else $error("late answer");
  a_wait_single: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
    else $error("wait low too long");
  a_data_upper: assert property (!AVS_WAITREQUEST |-> AVS_READDATA[31:8] == 24'h0)
    else $error("upper data set");
  // ==========================================
  // Output stage; seven cycles cover the input sync delay
  a_pin_inverse: assert property (FAULT_PIN_N != OUTPUT_HIZ)
    else $error("pin not inverse");
  a_clk_hiz: assert property (CLOCK_FAULT_IN [*7] |-> OUTPUT_HIZ)
    else $error("clock fault no hiz");
  a_ov_hiz: assert property (SUPPLY_OV_IN [*7] |-> OUTPUT_HIZ)
    else $error("ov no hiz");
  a_uv_hiz: assert property (SUPPLY_UV_IN [*7] |-> OUTPUT_HIZ)
    else $error("uv no hiz");
  a_ots_hiz: assert property (THERMAL_SHUTDOWN_IN [*7] |-> OUTPUT_HIZ)
    else $error("thermal no hiz");
  a_auto_recover: assert property (!(CLOCK_FAULT_IN || SUPPLY_OV_IN || SUPPLY_UV_IN
    || THERMAL_SHUTDOWN_IN) [*7] |-> !OUTPUT_HIZ)
    else $error("no recovery");
endmodule

bind fsr_top fsr_top_chk u_chk(.CORE_CLK(CORE_CLK), .RST_N(RST_N), .AVS_READ(AVS_READ),
  .AVS_WRITE(AVS_WRITE), .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
  .CLOCK_FAULT_IN(CLOCK_FAULT_IN), .SUPPLY_OV_IN(SUPPLY_OV_IN), .SUPPLY_UV_IN(SUPPLY_UV_IN),
  .THERMAL_SHUTDOWN_IN(THERMAL_SHUTDOWN_IN), .OUTPUT_HIZ(OUTPUT_HIZ),
  .FAULT_PIN_N(FAULT_PIN_N));

// ===== testbench/test_fault_status_reporting.sv
`timescale 1ns/1ns
module test_fault_status_reporting;
  logic CORE_CLK = 0, RST_N = 0, AVS_READ = 0, AVS_WRITE = 0;
  logic [9:0] AVS_ADDRESS = '0;
  logic [31:0] AVS_WRITEDATA = '0;
  logic [14:0] flt = '0;
  logic [31:0] AVS_READDATA;
  logic AVS_WAITREQUEST, OUTPUT_HIZ, FAULT_PIN_N, IRQ;
  logic [31:0] q[$];
  logic [7:0] lfsr = 8'h2B;
  int err_count = 0, comparisons = 0;
  // ==========================================
  // Fault vector packed so the index maps onto register bits
  fsr_top DUT(.CORE_CLK(CORE_CLK), .RST_N(RST_N), .AVS_ADDRESS(AVS_ADDRESS),
    .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA),
    .AVS_BYTEENABLE(4'hF), .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
    .CRC_ERROR_IN(flt[14]), .COEF_WRITE_ERROR_IN(flt[13]), .BOOT_LOAD_ERROR_IN(flt[12]),
    .CLOCK_FAULT_IN(flt[11]), .SUPPLY_OV_IN(flt[10]), .SUPPLY_UV_IN(flt[9]),
    .RIGHT_CURRENT_FAULT_IN(flt[8]), .LEFT_CURRENT_FAULT_IN(flt[7]),
    .THERMAL_SHUTDOWN_IN(flt[6]), .LEFT_CURRENT_WARN_IN(flt[5]),
    .RIGHT_CURRENT_WARN_IN(flt[4]), .THERMAL_WARN_IN(flt[3:0]), .OUTPUT_HIZ(OUTPUT_HIZ),
    .FAULT_PIN_N(FAULT_PIN_N), .IRQ(IRQ));
  // ==========================================
  // Tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic close_out();
    $display("comparisons=%0d mismatches=%0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge CORE_CLK);
  endtask
  // Request held until waitrequest seen low, then one idle cycle
  task automatic acc(input logic w, input logic [7:0] idx, input logic [7:0] d);
    int n;
    n = 0;
    AVS_ADDRESS <= {idx, 2'b00};
    AVS_WRITE <= w;
    AVS_READ <= !w;
    AVS_WRITEDATA <= {24'h0, d};
    do
    begin
      @(posedge CORE_CLK);
      n++;
    end
    while (AVS_WAITREQUEST !== 1'b0 && n < 40);
    if (n >= 40)
      err_count++;
    AVS_READ <= 0;
    AVS_WRITE <= 0;
    @(posedge CORE_CLK);
  endtask
  task automatic rd(input logic [7:0] idx, input logic [7:0] e);
    q.push_back({24'h0, e});
    acc(1'b0, idx, 8'h00);
  endtask
  // ==========================================
  // Read data taken at the edge that sees waitrequest low
  always @(posedge CORE_CLK)
    if (AVS_READ && AVS_WAITREQUEST === 1'b0 && q.size() > 0)
      chk(AVS_READDATA, q.pop_front());
  initial forever #25 CORE_CLK = ~CORE_CLK;
  initial
  begin
    #2000000;
    err_count++;
    close_out();
  end
  initial
  begin
    logic [7:0] idx, b, ib;
    wt(4);
    RST_N <= 1;
    wt(1);
    rd(8'h71, 8'h00);
    rd(8'h72, 8'h00);
    rd(8'h73, 8'h00);
    rd(8'h40, 8'h00);
    acc(1, 8'h7A, 8'h07);
    rd(8'h7A, 8'h07);
    for (int j = 0; j < 15; j++)
    begin
      idx = j < 6 ? 8'h73 : j < 9 ? 8'h72 : 8'h71;
      b = 8'h01 << (j < 6 ? j : j < 9 ? j - 6 : j < 12 ? j - 9 : j - 7);
      ib = j < 6 ? 8'h04 : j < 9 ? 8'h02 : 8'h01;
      flt[j] <= 1;
      wt(8);
      chk(FAULT_PIN_N, !(j inside {6, 9, 10, 11}));
      chk(IRQ, 1);
      rd(idx, b);
      lfsr = {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
      acc(1, idx, lfsr);
      rd(idx, b);
      flt[j] <= 0;
      wt(8);
      chk(FAULT_PIN_N, 1);
      rd(idx, j == 12 ? 8'h00 : b);
      rd(8'h79, ib);
      acc(1, 8'h78, 8'h80);
      rd(idx, 8'h00);
      acc(1, 8'h7B, 8'h07);
      wt(2);
      chk(IRQ, 0);
      $display("case %0d done", j);
    end
    // Masked source must not raise the interrupt
    acc(1, 8'h7A, 8'h00);
    flt[0] <= 1;
    wt(8);
    chk(IRQ, 0);
    $display("mask case done");
    close_out();
  end
endmodule
